// ===== bench/spp_port_tb.sv
// self-checking bench: device end and far end joined over the pin link
`timescale 1ns/1ps
`default_nettype none
module spp_port_tb;
  import spp_pkg::*;
  logic              clock, nrst, wrStb, rdStb, irq, last;
  logic              peerMaster, cpol, clock_phase_bit, start, done, busy;
  logic [ADDR_W-1:0] regAddr;
  logic [REG_W-1:0]  wrData, rdData, v, cfg;
  logic [BYTE_W-1:0] txByte, rxByte, a, b, shM, shS;
  int                error_cnt, compares, seed, h, e, gap, n;
  spp_if link ();
  spp_port i_spp_port (.clock, .nrst, .link(link.dev), .regAddr, .wrData, .wrStb, .rdStb, .rdData, .irq);
  spp_peer i_spp_peer (.clock, .nrst, .link(link.peer), .peerMaster, .cpol, .clock_phase_bit, .start, .txByte, .rxByte,
    .done, .busy);
  spp_properties i_spp_properties (.clock, .nrst, .devSckOe(link.devSckOe), .devMosiOe(link.devMosiOe),
    .devMisoOe(link.devMisoOe), .sck(link.sck), .devSelN(link.devSelN), .peerSelN(link.peerSelN));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic expire;
    check(9'h000, 9'h001);
    results();
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] d);
    regAddr <= ad;
    wrData  <= d;
    wrStb   <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, output logic [REG_W-1:0] d);
    regAddr <= ad;
    rdStb   <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    @(posedge clock);
    d = rdData;
  endtask
  task automatic kick(input logic [BYTE_W-1:0] t);
    txByte <= t;
    start  <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask
  // device master, far end slave, one byte each way at the given rate
  task automatic masterRun(input logic [2:0] code);
    cfg = 9'h060 | {4'h0, 1'($random(seed)), 1'($random(seed)), code};
    a = 8'($random(seed));
    b = 8'($random(seed));
    cpol <= cfg[4];
    clock_phase_bit <= cfg[3];
    wr(OFS_CTRL, cfg);
    wr(OFS_CTRL, cfg | 9'h100);
    kick(b);
    wr(OFS_DATA, {1'b0, a});
    if (code == 3'h4) wr(OFS_DATA, {1'b0, ~a});
    h = 2 << (code - 1);
    e = 0;
    gap = 0;
    last = link.sck;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
      @(posedge clock);
      gap++;
      if (link.sck !== last) begin
        if (e > 0) check(9'(gap), 9'(h));
        if (e % 2 == cfg[3]) begin
          shM = {shM[6:0], link.mosi};
          shS = {shS[6:0], link.miso};
        end
        e++;
        gap = 0;
        last = link.sck;
      end
    end
    if (irq !== 1'b1) expire();
    check(9'(e), 9'h010);
    check({1'b0, shM}, {1'b0, a});
    rd(OFS_STAT, v);
    check(v, (code == 3'h4) ? 9'h005 : 9'h001);
    if (code >= 3'h3) begin
      check({1'b0, shS}, {1'b0, b});
      rd(OFS_DATA, v);
      check(v, {1'b0, b});
      check({1'b0, rxByte}, {1'b0, a});
    end
    if (code == 3'h4) begin
      wr(OFS_MASK, 9'h004);
      check(9'(irq), 9'h001);
      wr(OFS_MASK, 9'h000);
      check(9'(irq), 9'h000);
      wr(OFS_MASK, 9'h001);
    end
    wr(OFS_STAT, 9'h007);
    check(9'(irq), 9'h000);
    wr(OFS_CTRL, cfg);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h50F390DD;
    {nrst, wrStb, rdStb, peerMaster, cpol, clock_phase_bit, start} = 7'h00;
    {regAddr, wrData, txByte} = 19'h00000;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int k = 0; k < 4; k++) begin
      rd(2'(k), v);
      check(v, 9'h000);
    end
    wr(OFS_MASK, 9'h001);
    for (int c = 1; c < 7; c++) masterRun(3'(c));
    // park the clock at polarity zero before selecting the far end again
    wr(OFS_CTRL, 9'h000);
    for (int r = 0; r < 2; r++) begin
      wr(OFS_CTRL, r ? 9'h167 : 9'h160);
      wr(OFS_DATA, 9'h0A5);
      e = 0;
      last = link.sck;
      repeat (300) begin
        @(posedge clock);
        if (link.sck !== last) e++;
        last = link.sck;
      end
      check(9'(e), 9'h000);
      rd(OFS_STAT, v);
      check(v, 9'h000);
    end
    wr(OFS_CTRL, 9'h000);
    for (int p = 0; p < 2; p++) begin
      cfg = 9'h040 | {4'h0, 1'($random(seed)), 1'(p), 3'h0};
      a = 8'($random(seed));
      b = 8'($random(seed));
      cpol <= cfg[4];
      clock_phase_bit <= cfg[3];
      peerMaster <= 1'b1;
      wr(OFS_CTRL, cfg);
      wr(OFS_DATA, {1'b0, a});
      check(9'(link.devMisoOe), 9'h000);
      kick(b);
      e = 0;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
        @(posedge clock);
        if (done === 1'b1) e++;
      end
      if (irq !== 1'b1) expire();
      check(9'(e), 9'h001);
      rd(OFS_DATA, v);
      check(v, {1'b0, b});
      check({1'b0, rxByte}, {1'b0, a});
      wr(OFS_STAT, 9'h007);
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clock);
      if (busy !== 1'b0) expire();
    end
    wr(OFS_MASK, 9'h003);
    wr(OFS_CTRL, 9'h063);
    cpol <= 1'b0;
    clock_phase_bit <= 1'b0;
    kick(8'h3C);
    for (n = 0; n < 20 && link.devSckOe !== 1'b0; n++) @(posedge clock);
    check(9'(link.devSckOe), 9'h000);
    rd(OFS_CTRL, v);
    check(v, 9'h003);
    rd(OFS_STAT, v);
    check(v, 9'h002);
    check(9'(irq), 9'h001);
    wr(OFS_CTRL, 9'h08B);
    wr(OFS_CTRL, 9'h003);
    rd(OFS_STAT, v);
    check(v, 9'h002);
    wr(OFS_STAT, 9'h002);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clock);
    if (busy !== 1'b0) expire();
    wr(OFS_CTRL, 9'h0EB);
    clock_phase_bit <= 1'b1;
    kick(8'hC3);
    cfg = 9'h000;
    for (n = 0; n < 100; n++) begin
      rd(OFS_STAT, v);
      cfg = cfg | v;
    end
    check(cfg, 9'h000);
    rd(OFS_CTRL, v);
    check(v, 9'h0EB);
    results();
  end
endmodule
`default_nettype wire

// ===== bench/spp_properties.sv
// concurrent checks on the pins between the serial port and its far party
`timescale 1ns/1ps
`default_nettype none
module spp_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic devSckOe,
  input wire logic devMosiOe,
  input wire logic devMisoOe,
  input wire logic sck,
  input wire logic devSelN,
  input wire logic peerSelN
);
  logic [5:0] edgeCnt_r;
  logic       sckLast_r;
  // ----------------------------------------------------------------
  // clock edge counting while the far end is selected
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    sckLast_r <= sck;
  end
  always_ff @(posedge clock) begin
    if (!nrst || peerSelN) begin
      edgeCnt_r <= 6'h00;
    end else if (devSckOe && (sck != sckLast_r)) begin
      edgeCnt_r <= edgeCnt_r + 6'h01;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  edge_count_a: assert property ($rose(peerSelN) |-> edgeCnt_r[3:0] == 4'h0)
    else $error("serial clock edges per frame not a multiple of sixteen");
  next_edge_a: assert property ((devSckOe && !peerSelN && sck != sckLast_r && edgeCnt_r[3:0] != 4'hF)
    |-> ##[1:130] (sck != sckLast_r || !devSckOe)) else $error("serial clock stalled inside a frame");
  half_min_a: assert property ((devSckOe && sck != sckLast_r) |=> sck == sckLast_r)
    else $error("serial clock half period below two clocks");
  miso_float_a: assert property (devSelN [*4] |-> !devMisoOe)
    else $error("slave data output driven while deselected");
  master_no_miso_a: assert property (devSckOe |-> !devMisoOe)
    else $error("master drives slave data line");
  oe_together_a: assert property (devSckOe == devMosiOe)
    else $error("clock and data enables of master disagree");
  reset_quiet_a: assert property ($rose(nrst) |-> !devSckOe && !devMosiOe && !devMisoOe && peerSelN)
    else $error("pins driven straight after reset");
  slave_quiet_a: assert property (devMisoOe |-> !devMosiOe)
    else $error("device drives both data lines");
endmodule
`default_nettype wire

// ===== src/spp_if.sv
// pin-level link between the serial port and its far party
`timescale 1ns/1ps
`default_nettype none
interface spp_if;
  logic devSckO, devSckOe, devMosiO, devMosiOe, devMisoO, devMisoOe, devSelO;
  logic peerSckO, peerSckOe, peerMosiO, peerMosiOe, peerMisoO, peerMisoOe, peerSelO, peerSelOe;
  logic sck, mosi, miso, devSelN, peerSelN;
  // ----------------------------------------------------------------
  // wire resolution, idle lines pulled high, clock pulled low
  // ----------------------------------------------------------------
  assign sck      = devSckOe ? devSckO : (peerSckOe ? peerSckO : 1'b0);
  assign mosi     = devMosiOe ? devMosiO : (peerMosiOe ? peerMosiO : 1'b1);
  assign miso     = devMisoOe ? devMisoO : (peerMisoOe ? peerMisoO : 1'b1);
  assign devSelN  = peerSelOe ? peerSelO : 1'b1;
  assign peerSelN = devSelO;
  modport dev  (output devSckO, devSckOe, devMosiO, devMosiOe, devMisoO, devMisoOe, devSelO,
                input  sck, mosi, miso, devSelN);
  modport peer (output peerSckO, peerSckOe, peerMosiO, peerMosiOe, peerMisoO, peerMisoOe,
                peerSelO, peerSelOe,
                input  sck, mosi, miso, peerSelN);
endinterface
`default_nettype wire

// ===== src/spp_peer.sv
// far party of the serial port: a plain master or slave with a byte port
`timescale 1ns/1ps
`default_nettype none
module spp_peer
  import spp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  spp_if.peer                    link,
  input  wire logic              peerMaster,
  input  wire logic              cpol,
  input  wire logic              clock_phase_bit,
  input  wire logic              start,
  input  wire logic [BYTE_W-1:0] txByte,
  output logic      [BYTE_W-1:0] rxByte,
  output logic                   done,
  output logic                   busy
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spp_state_type     st_r;
  logic [6:0]        halfCnt_r;
  logic [3:0]        edgeCnt_r;
  logic [BYTE_W-1:0] sh_r;
  logic [BYTE_W-1:0] rx_r;
  logic              cap_r, sckO_r, done_r;
  logic              sckS1_r, sckS2_r, sckS3_r, mosiS1_r, mosiS2_r, misoS1_r, misoS2_r, selS1_r, selS2_r;
  logic              tick, sel, lead, trail, inBit, lastTrail, load;

  assign tick      = (st_r != S_IDLE) && (halfCnt_r == PEER_HALF - HALF_ONE);
  assign sel       = ~selS2_r;
  assign lead      = peerMaster ? (tick && st_r == S_RUN && !edgeCnt_r[0])
                   : (sel & (cpol ? (sckS3_r & ~sckS2_r) : (sckS2_r & ~sckS3_r)));
  assign trail     = peerMaster ? (tick && st_r == S_RUN && edgeCnt_r[0])
                   : (sel & (cpol ? (sckS2_r & ~sckS3_r) : (sckS3_r & ~sckS2_r)));
  assign inBit     = peerMaster ? misoS2_r : mosiS2_r;
  assign lastTrail = trail && (edgeCnt_r == EDGE_LAST);
  assign load      = start && st_r == S_IDLE && edgeCnt_r == EDGE_ZERO;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      {sckS1_r, sckS2_r, sckS3_r} <= 3'h0;
      {mosiS1_r, mosiS2_r, misoS1_r, misoS2_r, selS1_r, selS2_r} <= 6'h3F;
    end else begin
      sckS1_r  <= link.sck;
      sckS2_r  <= sckS1_r;
      sckS3_r  <= sckS2_r;
      mosiS1_r <= link.mosi;
      mosiS2_r <= mosiS1_r;
      misoS1_r <= link.miso;
      misoS2_r <= misoS1_r;
      selS1_r  <= link.peerSelN;
      selS2_r  <= selS1_r;
    end
  end

  // ----------------------------------------------------------------
  // master sequencer: select low, sixteen edges, select held a half more
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= S_IDLE;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (load && peerMaster) begin
            st_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (lastTrail) begin
            st_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (tick) begin
            st_r <= S_IDLE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= 1'b0;
    end else if (st_r == S_IDLE) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= cpol;
    end else if (tick) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= (st_r == S_RUN) ? ~sckO_r : cpol;
    end else begin
      halfCnt_r <= halfCnt_r + HALF_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      edgeCnt_r <= EDGE_ZERO;
    end else if (peerMaster ? (st_r != S_RUN) : !sel) begin
      edgeCnt_r <= EDGE_ZERO;
    end else if (lead || trail) begin
      edgeCnt_r <= edgeCnt_r + EDGE_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sh_r   <= BYTE_RST;
      cap_r  <= 1'b0;
      rx_r   <= BYTE_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= lastTrail;
      if (lastTrail) begin
        rx_r <= {sh_r[BYTE_W-2:0], clock_phase_bit ? inBit : cap_r};
      end
      if (load) begin
        sh_r <= txByte;
      end else if (lead) begin
        if (!clock_phase_bit) begin
          cap_r <= inBit;
        end else if (edgeCnt_r != EDGE_ZERO) begin
          sh_r <= {sh_r[BYTE_W-2:0], cap_r};
        end
      end else if (trail) begin
        if (!clock_phase_bit) begin
          sh_r <= {sh_r[BYTE_W-2:0], cap_r};
        end else begin
          cap_r <= inBit;
        end
      end
    end
  end

  assign rxByte          = rx_r;
  assign done            = done_r;
  assign busy            = (st_r != S_IDLE) || (edgeCnt_r != EDGE_ZERO);
  assign link.peerSckO   = sckO_r;
  assign link.peerSckOe  = peerMaster;
  assign link.peerMosiO  = sh_r[BYTE_W-1];
  assign link.peerMosiOe = peerMaster;
  assign link.peerSelO   = (st_r == S_IDLE);
  assign link.peerSelOe  = peerMaster;
  assign link.peerMisoO  = sh_r[BYTE_W-1];
  assign link.peerMisoOe = ~peerMaster & sel;
endmodule
`default_nettype wire

// ===== src/spp_pkg.sv
// constants and types shared by both ends of the serial port link
package spp_pkg;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 2;
  localparam int          REG_W    = 9;
  localparam int          BYTE_W   = 8;
  localparam int          ST_W     = 3;
  localparam logic [1:0]  OFS_CTRL = 2'h0;
  localparam logic [1:0]  OFS_STAT = 2'h1;
  localparam logic [1:0]  OFS_DATA = 2'h2;
  localparam logic [1:0]  OFS_MASK = 2'h3;
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [2:0]  STAT_RST = 3'h0;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int          CTL_RATE  = 0;
  localparam int          CTL_CLOCK_PHASE_BIT  = 3;
  localparam int          CTL_CPOL  = 4;
  localparam int          CTL_MASTER_SELECT_BIT  = 5;
  localparam int          CTL_PORT_ENABLE_BIT  = 6;
  localparam int          CTL_SELECT_DISABLE_BIT = 7;
  localparam int          CTL_SELO  = 8;
  localparam int          ST_DONE   = 0;
  localparam int          ST_MODE_FAULT_FLAG   = 1;
  localparam int          ST_WCOL   = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  RATE_NONE_LO = 3'h0;
  localparam logic [2:0]  RATE_NONE_HI = 3'h7;
  localparam logic [2:0]  RATE_FIRST   = 3'h1;
  localparam logic [6:0]  HALF_BASE    = 7'h02;
  localparam logic [6:0]  HALF_ONE     = 7'h01;
  localparam logic [3:0]  EDGE_LAST    = 4'hF;
  localparam logic [3:0]  EDGE_ONE     = 4'h1;
  localparam logic [3:0]  EDGE_ZERO    = 4'h0;
  localparam logic [6:0]  PEER_HALF    = 7'h10;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN  = 2'b01,
    S_HOLD = 2'b11
  } spp_state_type;
endpackage

// ===== src/spp_port.sv
// byte-wide serial port, master or slave, with register port and interrupt
//
// Notes on behaviour
// - one byte per transfer, MSB first
// - master drives eight clock cycles, fewer if disabled or given rate code 0 or 7 mid-transfer
// - software holds slave select low throughout, via control bit 8
// - slave data output floats while deselected, unless phase and select disable are set
// - one master only; master sees select high
// - master selects at most one slave
// - master uses select and fault flag
// - select disabled master never flags fault
// - slave with phase and disable: always selected
// - clearing select disable leaves fault flag
// - software avoids disable when phase zero
// - rate codes 1..6 divide by 4..128
// - software avoids rate codes 0 and 7
// - select low in master sets fault, disables
// - data write starts; end sets done, loads
// - master bit picks master or slave
`timescale 1ns/1ps
`default_nettype none
module spp_port
  import spp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  spp_if.dev                     link,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [REG_W-1:0]  wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [REG_W-1:0]  rdData,
  output logic                   irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  ctrl_r;
  logic [ST_W-1:0]   stat_r;
  logic [ST_W-1:0]   mask_r;
  logic [BYTE_W-1:0] rxData_r;
  logic [BYTE_W-1:0] sh_r;
  logic              cap_r;
  logic [3:0]        edgeCnt_r;
  logic [6:0]        halfCnt_r;
  logic              sckO_r;
  spp_state_type     mst_r;
  logic              sckS1_r, sckS2_r, sckS3_r;
  logic              mosiS1_r, mosiS2_r;
  logic              misoS1_r, misoS2_r;
  logic              ssS1_r, ssS2_r;
  logic [REG_W-1:0]  rdData_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic       master_select_bit, port_enable_bit, clock_phase_bit, cpol, select_disable_bit;
  logic [2:0] rate;
  logic       rateOk, masterOn, slaveSel, slaveOn;
  logic [6:0] halfLen;
  logic       halfTick, mLead, mTrail, sLead, sTrail, edgeLead, edgeTrail;
  logic       dataWr, busy, load, mStart, wcolSet, lastTrail, modfSet, inBit;
  logic [ST_W-1:0] statSet, statClr;

  assign master_select_bit     = ctrl_r[CTL_MASTER_SELECT_BIT];
  assign port_enable_bit     = ctrl_r[CTL_PORT_ENABLE_BIT];
  assign clock_phase_bit     = ctrl_r[CTL_CLOCK_PHASE_BIT];
  assign cpol     = ctrl_r[CTL_CPOL];
  assign select_disable_bit    = ctrl_r[CTL_SELECT_DISABLE_BIT];
  assign rate     = ctrl_r[CTL_RATE +: 3];
  assign rateOk   = (rate != RATE_NONE_LO) && (rate != RATE_NONE_HI);
  assign halfLen  = HALF_BASE << (rate - RATE_FIRST);
  assign masterOn = port_enable_bit & master_select_bit;
  assign slaveSel = ~ssS2_r | (clock_phase_bit & select_disable_bit);
  assign slaveOn  = port_enable_bit & ~master_select_bit & slaveSel;

  assign halfTick = (mst_r == S_RUN) && (halfCnt_r == halfLen - HALF_ONE);
  assign mLead    = halfTick & ~edgeCnt_r[0];
  assign mTrail   = halfTick & edgeCnt_r[0];
  assign sLead    = slaveOn & (cpol ? (sckS3_r & ~sckS2_r) : (sckS2_r & ~sckS3_r));
  assign sTrail   = slaveOn & (cpol ? (sckS2_r & ~sckS3_r) : (sckS3_r & ~sckS2_r));
  assign edgeLead  = master_select_bit ? mLead : sLead;
  assign edgeTrail = master_select_bit ? mTrail : sTrail;
  assign inBit     = master_select_bit ? misoS2_r : mosiS2_r;

  assign dataWr    = wrStb && (regAddr == OFS_DATA);
  assign busy      = (mst_r != S_IDLE) || (edgeCnt_r != EDGE_ZERO);
  assign load      = dataWr & ~busy;
  assign mStart    = load & masterOn & rateOk;
  assign wcolSet   = dataWr & busy;
  assign lastTrail = edgeTrail && (edgeCnt_r == EDGE_LAST);
  assign modfSet   = masterOn & ~select_disable_bit & ~ssS2_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sckS1_r  <= 1'b0;
      sckS2_r  <= 1'b0;
      sckS3_r  <= 1'b0;
      mosiS1_r <= 1'b1;
      mosiS2_r <= 1'b1;
      misoS1_r <= 1'b1;
      misoS2_r <= 1'b1;
      ssS1_r   <= 1'b1;
      ssS2_r   <= 1'b1;
    end else begin
      sckS1_r  <= link.sck;
      sckS2_r  <= sckS1_r;
      sckS3_r  <= sckS2_r;
      mosiS1_r <= link.mosi;
      mosiS2_r <= mosiS1_r;
      misoS1_r <= link.miso;
      misoS2_r <= misoS1_r;
      ssS1_r   <= link.devSelN;
      ssS2_r   <= ssS1_r;
    end
  end

  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mst_r <= S_IDLE;
    end else begin
      unique case (mst_r)
        S_IDLE: begin
          if (mStart) begin
            mst_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (lastTrail || !masterOn || !rateOk) begin
            mst_r <= S_IDLE;
          end
        end
        default: begin
          mst_r <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= 1'b0;
    end else if (mst_r != S_RUN) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= cpol;
    end else if (halfTick) begin
      halfCnt_r <= 7'h00;
      sckO_r    <= ~sckO_r;
    end else begin
      halfCnt_r <= halfCnt_r + HALF_ONE;
    end
  end

  // ----------------------------------------------------------------
  // shift engine, shared by both modes
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      edgeCnt_r <= EDGE_ZERO;
    end else if ((!master_select_bit && !slaveOn) || (master_select_bit && mst_r != S_RUN)) begin
      edgeCnt_r <= EDGE_ZERO;
    end else if (edgeLead || edgeTrail) begin
      edgeCnt_r <= edgeCnt_r + EDGE_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sh_r  <= BYTE_RST;
      cap_r <= 1'b0;
    end else if (load) begin
      sh_r <= wrData[BYTE_W-1:0];
    end else if (edgeLead) begin
      if (!clock_phase_bit) begin
        cap_r <= inBit;
      end else if (edgeCnt_r != EDGE_ZERO) begin
        sh_r <= {sh_r[BYTE_W-2:0], cap_r};
      end
    end else if (edgeTrail) begin
      if (!clock_phase_bit) begin
        sh_r <= {sh_r[BYTE_W-2:0], cap_r};
      end else begin
        cap_r <= inBit;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rxData_r <= BYTE_RST;
    end else if (lastTrail) begin
      rxData_r <= {sh_r[BYTE_W-2:0], clock_phase_bit ? inBit : cap_r};
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    statSet          = STAT_RST;
    statSet[ST_DONE] = lastTrail;
    statSet[ST_MODE_FAULT_FLAG] = modfSet;
    statSet[ST_WCOL] = wcolSet;
    statClr          = (wrStb && regAddr == OFS_STAT) ? wrData[ST_W-1:0] : STAT_RST;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stat_r <= STAT_RST;
    end else begin
      stat_r <= (stat_r & ~statClr) | statSet;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (wrStb && regAddr == OFS_CTRL) begin
        ctrl_r <= wrData;
      end
      if (modfSet) begin
        ctrl_r[CTL_PORT_ENABLE_BIT] <= 1'b0;
        ctrl_r[CTL_MASTER_SELECT_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mask_r <= STAT_RST;
    end else if (wrStb && regAddr == OFS_MASK) begin
      mask_r <= wrData[ST_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdData_r <= CTRL_RST;
    end else if (rdStb) begin
      unique case (regAddr)
        OFS_CTRL: rdData_r <= ctrl_r;
        OFS_STAT: rdData_r <= {{(REG_W-ST_W){1'b0}}, stat_r};
        OFS_DATA: rdData_r <= {{(REG_W-BYTE_W){1'b0}}, rxData_r};
        OFS_MASK: rdData_r <= {{(REG_W-ST_W){1'b0}}, mask_r};
      endcase
    end else begin
      rdData_r <= CTRL_RST;
    end
  end

  assign rdData = rdData_r;
  assign irq    = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign link.devSckO   = sckO_r;
  assign link.devSckOe  = masterOn;
  assign link.devMosiO  = sh_r[BYTE_W-1];
  assign link.devMosiOe = masterOn;
  assign link.devMisoO  = sh_r[BYTE_W-1];
  assign link.devMisoOe = slaveOn;
  assign link.devSelO   = ~ctrl_r[CTL_SELO];
endmodule
`default_nettype wire
